// File: hdl/t2crb_pkg.sv
/*
 * Package for the second timer block: register offsets, control bit
 * positions, reset values, timing counts and carrier structs.
 * Assumes an 8-bit special function register port from the core.
 */
package t2crb_pkg;
   // ----------------------------------------------------------------
   // register addresses
   // ----------------------------------------------------------------
   localparam logic [7:0] ADDR_CONTROL = 8'hc8;
   localparam logic [7:0] ADDR_MODE = 8'hc9;
   localparam logic [7:0] ADDR_CAP_LOW = 8'hca;
   localparam logic [7:0] ADDR_CAP_HIGH = 8'hcb;
   localparam logic [7:0] ADDR_COUNT_LOW = 8'hcc;
   localparam logic [7:0] ADDR_COUNT_HIGH = 8'hcd;
   // ----------------------------------------------------------------
   // control bit positions
   // ----------------------------------------------------------------
   localparam int BIT_OVF = 7;
   localparam int BIT_EXT = 6;
   localparam int BIT_RCLK = 5;
   localparam int BIT_TCLK = 4;
   localparam int BIT_TRIG_EN = 3;
   localparam int BIT_RUN = 2;
   localparam int BIT_CNT_SEL = 1;
   localparam int BIT_CAP_SEL = 0;
   // mode register bits
   localparam int BIT_CAP_CLR = 3;
   localparam int BIT_DOWN_EN = 0;
   localparam logic [7:0] MODE_MASK = 8'h09;
   // ----------------------------------------------------------------
   // reset values and timing
   // ----------------------------------------------------------------
   localparam logic [7:0] CONTROL_RESET = 8'h00;
   localparam logic [7:0] MODE_RESET = 8'h00;
   localparam logic [15:0] COUNT_RESET = 16'h0000;
   localparam logic [15:0] COUNT_ALL_ONES = 16'hffff;
   localparam int BAUD_CLOCKS_PER_TICK = 2;
   localparam int FAST_CLOCKS_PER_TICK = 4;
   localparam int SLOW_CLOCKS_PER_TICK = 12;

   typedef struct packed {
      logic wr;
      logic rd;
      logic [7:0] addr;
      logic [7:0] wdata;
   } t2crb_sfr_s;

   typedef struct packed {
      logic rx_tick;
      logic tx_tick;
   } t2crb_baud_s;
endpackage

// File: hdl/t2crb_sync.sv
/*
 * Three-stage pin synchroniser with falling-edge detect.
 * Assumes the pin is asynchronous to CLK_I.
 */
`timescale 1ns/1ps
`default_nettype none
module t2crb_sync
(
   input wire logic clk_i,
   input wire logic rst_n_i,
   input wire logic pin_i,
   output logic level_o,
   output logic fall_o
);
   logic [2:0] stage_reg;
   logic level_reg;

   // ----------------------------------------------------------------
   // sampling
   // ----------------------------------------------------------------
   // stage 0 read only by stage 1; level changes only when 1 and 2 agree
   always_ff @(posedge clk_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
      begin
         stage_reg <= 3'h7;
         level_reg <= 1'b1;
      end
      else
      begin
         stage_reg <= {stage_reg[1:0], pin_i};
         if (stage_reg[1] == stage_reg[2])
            level_reg <= stage_reg[2];
      end
   end

   wire agree_low = (stage_reg[1] == stage_reg[2]) && !stage_reg[2];
   assign level_o = level_reg;
   assign fall_o = level_reg && agree_low;
endmodule
`default_nettype wire

// File: hdl/t2crb_timer.sv
/*
 * Second timer of the core: 16-bit count with capture, auto-reload,
 * up/down counting and baud-rate generation for serial port 0.
 * Assumes the core presents single-cycle register read/write strobes
 * and supplies the first timer overflow and serial mode as inputs.
 */
//
// Functional notes
// - overflow flag on wrap or down match
// - hardware sets overflow only without baud clocks
// - external flag from trigger edge or down-enabled overflow
// - trigger-set flag cleared by software; raises request
// - receive clock from timer one or two
// - transmit clock from timer one or two
// - either clock bit selects baud mode
// - trigger ignored unless enabled, not baud
// - run bit gates counting, holds count
// - timer rate by speed bit, or pin
// - baud mode ticks every two clocks
// - baud mode forces auto-reload on overflow
// - reload mode reloads on overflow, trigger
// - capture mode latches count on trigger
// - control register at C8h, fixed bit order
// - capture bytes latch count or give reload
// - down enable and pin set direction
// - capture may clear count afterwards
`timescale 1ns/1ps
`default_nettype none
module t2crb_timer
   import t2crb_pkg::*;
(
   input wire logic CLK_I,
   input wire logic RST_N_I,
   input wire t2crb_pkg::t2crb_sfr_s SFR_I,
   input wire logic SPEED_SELECT_I,
   input wire logic TIMER1_OVERFLOW_I,
   input wire logic [1:0] SERIAL_MODE_I,
   input wire logic TIMER_INT_ENABLE_I,
   input wire logic COUNT_INPUT_PIN_I,
   input wire logic EXT_TRIGGER_PIN_I,
   output logic [7:0] SFR_RDATA_O,
   output logic TIMER2_IRQ_O,
   output t2crb_pkg::t2crb_baud_s BAUD_O
);
   import t2crb_pkg::*;

   logic [7:0] control_reg;
   logic [7:0] mode_reg;
   logic [15:0] capture_reg;
   logic [15:0] count_reg;
   logic [3:0] prescale_reg;
   logic [7:0] rdata_reg;
   logic irq_reg;
   t2crb_baud_s baud_reg;
   logic [7:0] control_next;
   logic [15:0] capture_next;
   logic [15:0] count_next;
   logic [3:0] prescale_next;

   // ----------------------------------------------------------------
   // pin conditioning
   // ----------------------------------------------------------------
   wire count_pin_fall;
   wire trig_pin_level;
   wire trig_pin_fall;

   t2crb_sync u_count_sync
   (
      .clk_i(CLK_I),
      .rst_n_i(RST_N_I),
      .pin_i(COUNT_INPUT_PIN_I),
      .level_o(),
      .fall_o(count_pin_fall)
   );

   t2crb_sync u_trig_sync
   (
      .clk_i(CLK_I),
      .rst_n_i(RST_N_I),
      .pin_i(EXT_TRIGGER_PIN_I),
      .level_o(trig_pin_level),
      .fall_o(trig_pin_fall)
   );

   // ----------------------------------------------------------------
   // register decode
   // ----------------------------------------------------------------
   function automatic logic hit(input t2crb_sfr_s bus, input logic [7:0] addr);
      hit = bus.wr && (bus.addr == addr);
   endfunction

   wire wr_control = hit(SFR_I, ADDR_CONTROL);
   wire wr_mode = hit(SFR_I, ADDR_MODE);
   wire wr_cap_low = hit(SFR_I, ADDR_CAP_LOW);
   wire wr_cap_high = hit(SFR_I, ADDR_CAP_HIGH);
   wire wr_count_low = hit(SFR_I, ADDR_COUNT_LOW);
   wire wr_count_high = hit(SFR_I, ADDR_COUNT_HIGH);

   // ----------------------------------------------------------------
   // mode decode
   // ----------------------------------------------------------------
   wire rclk = control_reg[BIT_RCLK];
   wire tclk = control_reg[BIT_TCLK];
   wire baud_mode = rclk || tclk;
   wire trig_en = control_reg[BIT_TRIG_EN];
   wire run = control_reg[BIT_RUN];
   wire cnt_sel = control_reg[BIT_CNT_SEL];
   wire capture_mode = control_reg[BIT_CAP_SEL] && !baud_mode;
   wire down_en = mode_reg[BIT_DOWN_EN];
   wire cap_clr = mode_reg[BIT_CAP_CLR];
   // trigger ignored when disabled or generating baud clocks
   wire trig_event = trig_pin_fall && trig_en && !baud_mode;
   // direction only applies in plain auto-reload; pin low counts down
   wire count_down = !capture_mode && !baud_mode && down_en && !trig_pin_level;

   // ----------------------------------------------------------------
   // tick generation
   // ----------------------------------------------------------------
   wire [3:0] tick_period = baud_mode ? 4'(BAUD_CLOCKS_PER_TICK) :
      (SPEED_SELECT_I ? 4'(FAST_CLOCKS_PER_TICK) : 4'(SLOW_CLOCKS_PER_TICK));
   wire prescale_done = (prescale_reg >= tick_period - 4'h1);
   // baud mode ignores the counter select
   wire use_pin = cnt_sel && !baud_mode;
   wire tick = run && (use_pin ? count_pin_fall : prescale_done);

   always_comb
   begin
      prescale_next = prescale_reg;
      if (!run || use_pin || prescale_done)
         prescale_next = 4'h0;
      else
         prescale_next = prescale_reg + 4'h1;
   end

   // ----------------------------------------------------------------
   // count, overflow and capture
   // ----------------------------------------------------------------
   // up overflow wraps from all ones; down overflow is match with capture
   wire up_overflow = tick && !count_down && (count_reg == COUNT_ALL_ONES);
   wire down_overflow = tick && count_down && (count_reg == capture_reg);
   wire overflow = up_overflow || down_overflow;
   wire reload_on_ovf = up_overflow && !capture_mode;
   wire reload_on_trig = trig_event && !capture_mode;
   wire capture_now = trig_event && capture_mode;

   always_comb
   begin
      count_next = count_reg;
      if (tick)
         count_next = count_down ? count_reg - 16'h0001 : count_reg + 16'h0001;
      if (reload_on_ovf || reload_on_trig)
         count_next = capture_reg;
      if (down_overflow)
         count_next = COUNT_ALL_ONES;
      if (capture_now && cap_clr)
         count_next = COUNT_RESET;
      if (wr_count_low)
         count_next = {count_reg[15:8], SFR_I.wdata};
      if (wr_count_high)
         count_next = {SFR_I.wdata, count_reg[7:0]};
   end

   always_comb
   begin
      capture_next = capture_reg;
      if (capture_now)
         capture_next = count_reg;
      if (wr_cap_low)
         capture_next = {capture_reg[15:8], SFR_I.wdata};
      if (wr_cap_high)
         capture_next = {SFR_I.wdata, capture_reg[7:0]};
   end

   // ----------------------------------------------------------------
   // flags
   // ----------------------------------------------------------------
   wire set_ovf = overflow && !baud_mode;
   // external flag: trigger edge outside baud mode, overflow only with down enable
   wire set_ext = trig_event || (overflow && down_en && !capture_mode && !baud_mode);
   wire sw_set_ext = wr_control && SFR_I.wdata[BIT_EXT] && !control_reg[BIT_EXT];

   always_comb
   begin
      control_next = control_reg;
      if (wr_control)
         control_next = SFR_I.wdata;
      // hardware set wins over a software clear in the same cycle
      if (set_ovf)
         control_next[BIT_OVF] = 1'b1;
      if (set_ext)
         control_next[BIT_EXT] = 1'b1;
   end

   // request pulses on the event itself, not the level of the flag
   wire irq_event = (sw_set_ext || trig_event || set_ovf) && TIMER_INT_ENABLE_I;

   // ----------------------------------------------------------------
   // baud clocks
   // ----------------------------------------------------------------
   wire async_mode = SERIAL_MODE_I[0]; // modes 1 and 3
   wire t2_ovf_baud = up_overflow && baud_mode;
   wire rx_tick = async_mode && (rclk ? t2_ovf_baud : TIMER1_OVERFLOW_I);
   wire tx_tick = async_mode && (tclk ? t2_ovf_baud : TIMER1_OVERFLOW_I);

   // ----------------------------------------------------------------
   // read mux
   // ----------------------------------------------------------------
   wire [7:0] rd_mux =
      (SFR_I.addr == ADDR_CONTROL) ? control_reg :
      (SFR_I.addr == ADDR_MODE) ? (mode_reg & MODE_MASK) :
      (SFR_I.addr == ADDR_CAP_LOW) ? capture_reg[7:0] :
      (SFR_I.addr == ADDR_CAP_HIGH) ? capture_reg[15:8] :
      (SFR_I.addr == ADDR_COUNT_LOW) ? count_reg[7:0] :
      (SFR_I.addr == ADDR_COUNT_HIGH) ? count_reg[15:8] : 8'h00;

   // ----------------------------------------------------------------
   // control and mode registers
   // ----------------------------------------------------------------
   always_ff @(posedge CLK_I or negedge RST_N_I)
   begin
      if (!RST_N_I)
         control_reg <= CONTROL_RESET;
      else
         control_reg <= control_next;
   end

   // only the capture-clear and down-enable bits are kept
   always_ff @(posedge CLK_I or negedge RST_N_I)
   begin
      if (!RST_N_I)
         mode_reg <= MODE_RESET;
      else if (wr_mode)
         mode_reg <= SFR_I.wdata & MODE_MASK;
   end

   // ----------------------------------------------------------------
   // count state
   // ----------------------------------------------------------------
   always_ff @(posedge CLK_I or negedge RST_N_I)
   begin
      if (!RST_N_I)
         capture_reg <= COUNT_RESET;
      else
         capture_reg <= capture_next;
   end

   always_ff @(posedge CLK_I or negedge RST_N_I)
   begin
      if (!RST_N_I)
         count_reg <= COUNT_RESET;
      else
         count_reg <= count_next;
   end

   // prescaler restarts whenever the timer stops or follows the pin
   always_ff @(posedge CLK_I or negedge RST_N_I)
   begin
      if (!RST_N_I)
         prescale_reg <= 4'h0;
      else
         prescale_reg <= prescale_next;
   end

   // ----------------------------------------------------------------
   // output registers
   // ----------------------------------------------------------------
   // read data holds until the next read strobe
   always_ff @(posedge CLK_I or negedge RST_N_I)
   begin
      if (!RST_N_I)
         rdata_reg <= 8'h00;
      else if (SFR_I.rd)
         rdata_reg <= rd_mux;
   end

   // one-cycle request per event; a held flag never repeats it
   always_ff @(posedge CLK_I or negedge RST_N_I)
   begin
      if (!RST_N_I)
         irq_reg <= 1'b0;
      else
         irq_reg <= irq_event;
   end

   // registered so the serial port sees clean single-cycle ticks
   always_ff @(posedge CLK_I or negedge RST_N_I)
   begin
      if (!RST_N_I)
         baud_reg <= '0;
      else
         baud_reg <= '{rx_tick: rx_tick, tx_tick: tx_tick};
   end

   assign SFR_RDATA_O = rdata_reg;
   assign TIMER2_IRQ_O = irq_reg;
   assign BAUD_O = baud_reg;
endmodule
`default_nettype wire

// File: testbench/t2crb_timer_chk.sv
/*
 * Port checker for the second timer block.
 * Assumes it is bound to t2crb_timer and sees only that module's ports.
 */
`timescale 1ns/1ps
`default_nettype none
module t2crb_timer_chk
(
   input wire logic CLK_I,
   input wire logic RST_N_I,
   input wire t2crb_pkg::t2crb_sfr_s SFR_I,
   input wire logic SPEED_SELECT_I,
   input wire logic TIMER1_OVERFLOW_I,
   input wire logic [1:0] SERIAL_MODE_I,
   input wire logic TIMER_INT_ENABLE_I,
   input wire logic COUNT_INPUT_PIN_I,
   input wire logic EXT_TRIGGER_PIN_I,
   input wire logic [7:0] SFR_RDATA_O,
   input wire logic TIMER2_IRQ_O,
   input wire t2crb_pkg::t2crb_baud_s BAUD_O
);
   import t2crb_pkg::*;
   logic [7:0] ctl_reg;
   wire logic mapped = SFR_I.addr >= ADDR_CONTROL && SFR_I.addr <= ADDR_COUNT_HIGH;
   // shadow of the software-owned control bits; hardware only touches 7:6
   always_ff @(posedge CLK_I or negedge RST_N_I)
      if (!RST_N_I)
         ctl_reg <= CONTROL_RESET;
      else if (SFR_I.wr && SFR_I.addr == ADDR_CONTROL)
         ctl_reg <= SFR_I.wdata;
   default clocking @(posedge CLK_I);
   endclocking
   default disable iff (!RST_N_I);
   chk_rx_timer_one: assert property (SERIAL_MODE_I[0] && !ctl_reg[BIT_RCLK]
      && TIMER1_OVERFLOW_I |=> BAUD_O.rx_tick) else $error("rx tick missing");
   chk_tx_timer_one: assert property (SERIAL_MODE_I[0] && !ctl_reg[BIT_TCLK]
      && TIMER1_OVERFLOW_I |=> BAUD_O.tx_tick) else $error("tx tick missing");
   chk_baud_quiet: assert property (!SERIAL_MODE_I[0]
      |=> !BAUD_O.rx_tick && !BAUD_O.tx_tick) else $error("tick outside modes 1 and 3");
   chk_baud_spacing: assert property (BAUD_O.rx_tick && ctl_reg[BIT_RCLK]
      && $stable(ctl_reg) |=> !BAUD_O.rx_tick) else $error("baud ticks too close");
   chk_irq_masked: assert property (!TIMER_INT_ENABLE_I ##1 !TIMER_INT_ENABLE_I
      |-> !TIMER2_IRQ_O) else $error("interrupt while disabled");
   chk_rdata_hold: assert property (!SFR_I.rd |=> $stable(SFR_RDATA_O))
      else $error("read data changed without read");
   chk_unmapped_read: assert property (SFR_I.rd && !mapped
      |=> SFR_RDATA_O == 8'h00) else $error("unmapped read not zero");
   chk_control_readback: assert property (SFR_I.rd && SFR_I.addr == ADDR_CONTROL
      |=> SFR_RDATA_O[5:0] == $past(ctl_reg[5:0])) else $error("control bits wrong");
   cover property (BAUD_O.rx_tick && ctl_reg[BIT_RCLK]);
   cover property (TIMER2_IRQ_O);
   cover property (SFR_I.rd && !mapped);
   cover property (BAUD_O.tx_tick && ctl_reg[BIT_TCLK]);
endmodule
bind t2crb_timer t2crb_timer_chk u_chk (.CLK_I, .RST_N_I, .SFR_I, .SPEED_SELECT_I,
   .TIMER1_OVERFLOW_I, .SERIAL_MODE_I, .TIMER_INT_ENABLE_I, .COUNT_INPUT_PIN_I,
   .EXT_TRIGGER_PIN_I, .SFR_RDATA_O, .TIMER2_IRQ_O, .BAUD_O);
`default_nettype wire

// File: testbench/t2crb_pins.sv
/*
 * Far-side model: count pin, trigger pin and first timer overflow.
 * Assumes pins idle high through pull-ups and one core clock.
 */
`timescale 1ns/1ps
`default_nettype none
module t2crb_pins
(
   input wire logic clk_i,
   output logic count_pin_o,
   output logic trig_pin_o,
   output logic t1_ovf_o
);
   int n = 0;
   initial
   begin
      count_pin_o = 1'b1;
      trig_pin_o = 1'b1;
      t1_ovf_o = 1'b0;
   end
   // period 16 so it never matches the second timer's baud gap
   always @(posedge clk_i)
   begin
      n <= n + 1;
      t1_ovf_o <= (n[3:0] == 4'hf);
   end
   // trigger level sets the count direction when down count is on
   task automatic hold_trig(input bit lvl);
      trig_pin_o <= lvl;
   endtask
   // low for 4 clocks, long enough for the three-stage synchroniser
   task automatic pulse(input bit trig);
      if (trig)
         trig_pin_o <= 1'b0;
      else
         count_pin_o <= 1'b0;
      repeat (4) @(posedge clk_i);
      trig_pin_o <= 1'b1;
      count_pin_o <= 1'b1;
      repeat (4) @(posedge clk_i);
   endtask
endmodule
`default_nettype wire

// File: testbench/timer2_capture_reload_baud_tb_top.sv
/*
 * Self-checking bench for the second timer block.
 * Assumes the checker binds itself and the pin model drives the pins.
 */
`timescale 1ns/1ps
`default_nettype none
module timer2_capture_reload_baud_tb_top;
   import t2crb_pkg::*;
   logic clk = 1'b0;
   logic rst_n = 1'b0;
   t2crb_sfr_s sfr = '0;
   logic speed = 1'b1;
   logic [1:0] smode = 2'b01;
   logic int_en = 1'b1;
   logic cnt_pin, trig_pin, t1_ovf, irq;
   logic [7:0] rdata;
   t2crb_baud_s baud;
   int miscompares = 0;
   int comparisons = 0;
   int cyc = 0, irqs = 0, last_rx = 0, rx_gap = 0, last_tx = 0, tx_gap = 0;
   logic rd_d = 1'b0;
   logic [7:0] exp_q[$];
   string name_q[$];
   logic [7:0] bctl[3] = '{8'h34, 8'h36, 8'h15};
   logic [15:0] bgap[3] = '{16'h0008, 16'h0008, 16'h0010};
   t2crb_timer dut (.CLK_I(clk), .RST_N_I(rst_n), .SFR_I(sfr), .SPEED_SELECT_I(speed),
      .TIMER1_OVERFLOW_I(t1_ovf), .SERIAL_MODE_I(smode), .TIMER_INT_ENABLE_I(int_en),
      .COUNT_INPUT_PIN_I(cnt_pin), .EXT_TRIGGER_PIN_I(trig_pin), .SFR_RDATA_O(rdata),
      .TIMER2_IRQ_O(irq), .BAUD_O(baud));
   t2crb_pins u_pins (.clk_i(clk), .count_pin_o(cnt_pin), .trig_pin_o(trig_pin),
      .t1_ovf_o(t1_ovf));
   task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
      comparisons++;
      if (seen !== exp)
      begin
         miscompares++;
         $display("ERROR %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic stop_test();
      if (miscompares == 0 && comparisons > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask
   // one access, then an idle cycle so no strobe is driven twice in a step
   task automatic acc(input logic w, input logic [7:0] a, input logic [7:0] d);
      sfr <= '{wr: w, rd: !w, addr: a, wdata: d};
      @(posedge clk);
      sfr <= '0;
      @(posedge clk);
   endtask
   task automatic rd(input logic [7:0] a, input logic [7:0] e, input string n);
      exp_q.push_back(e);
      name_q.push_back(n);
      acc(1'b0, a, 8'h00);
   endtask
   task automatic wr16(input logic [7:0] a, input logic [15:0] v);
      acc(1'b1, a, v[7:0]);
      acc(1'b1, a + 8'h01, v[15:8]);
   endtask
   task automatic rd16(input logic [7:0] a, input logic [15:0] e, input string n);
      rd(a, e[7:0], n);
      rd(a + 8'h01, e[15:8], n);
   endtask
   initial
   begin
      forever #5 clk = ~clk;
   end
   always @(posedge clk)
   begin
      cyc <= cyc + 1;
      rd_d <= sfr.rd;
      if (irq === 1'b1)
         irqs <= irqs + 1;
      if (baud.rx_tick === 1'b1)
      begin
         rx_gap <= cyc - last_rx;
         last_rx <= cyc;
      end
      if (baud.tx_tick === 1'b1)
      begin
         tx_gap <= cyc - last_tx;
         last_tx <= cyc;
      end
      if (rd_d)
         check(name_q.pop_front(), rdata, exp_q.pop_front());
   end
   initial
   begin
      repeat (20000) @(posedge clk);
      miscompares++;
      stop_test();
   end
   initial
   begin
      int r, n, i0;
      void'($urandom(32'hb673));
      repeat (3) @(posedge clk);
      rst_n <= 1'b1;
      @(posedge clk);
      for (int a = 8'hc7; a <= 8'hce; a++)
         rd(a[7:0], 8'h00, "reset or unmapped");
      acc(1'b1, ADDR_MODE, 8'hff);
      rd(ADDR_MODE, MODE_MASK, "mode bits");
      acc(1'b1, ADDR_MODE, 8'h00);
      for (int sp = 0; sp < 2; sp++)
      begin
         speed <= sp[0];
         wr16(ADDR_CAP_LOW, 16'hfff0);
         wr16(ADDR_COUNT_LOW, 16'hfffe);
         repeat (30) @(posedge clk);
         rd16(ADDR_COUNT_LOW, 16'hfffe, "stopped count");
         i0 = irqs;
         acc(1'b1, ADDR_CONTROL, 8'h04);
         for (n = 0; irqs == i0 && n < 200; n++)
            @(posedge clk);
         check("fast ticks", 16'(n < 12), 16'(sp));
         rd(ADDR_CONTROL, 8'h84, "overflow flag");
         rd(ADDR_COUNT_HIGH, 8'hff, "reloaded high byte");
         acc(1'b1, ADDR_CONTROL, 8'h00);
         rd(ADDR_CONTROL, 8'h00, "flag cleared");
      end
      r = $urandom & 32'h7fff;
      wr16(ADDR_COUNT_LOW, r[15:0]);
      acc(1'b1, ADDR_CONTROL, 8'h07);
      repeat (3) u_pins.pulse(1'b0);
      i0 = irqs;
      u_pins.pulse(1'b1);
      rd16(ADDR_COUNT_LOW, r[15:0] + 16'h0003, "pin count");
      rd16(ADDR_CAP_LOW, 16'hfff0, "capture untouched");
      check("ignored trigger", 16'(irqs - i0), 16'h0000);
      acc(1'b1, ADDR_CONTROL, 8'h0f);
      u_pins.pulse(1'b1);
      rd16(ADDR_CAP_LOW, r[15:0] + 16'h0003, "captured count");
      rd(ADDR_CONTROL, 8'h4f, "trigger flag");
      check("trigger interrupt", 16'(irqs - i0), 16'h0001);
      acc(1'b1, ADDR_MODE, 8'h08);
      u_pins.pulse(1'b1);
      rd16(ADDR_COUNT_LOW, 16'h0000, "count cleared");
      acc(1'b1, ADDR_MODE, 8'h00);
      int_en <= 1'b0;
      acc(1'b1, ADDR_CONTROL, 8'h0e);
      i0 = irqs;
      u_pins.pulse(1'b1);
      rd16(ADDR_COUNT_LOW, r[15:0] + 16'h0003, "trigger reload");
      rd(ADDR_CONTROL, 8'h4e, "flag while masked");
      check("masked interrupt", 16'(irqs - i0), 16'h0000);
      int_en <= 1'b1;
      acc(1'b1, ADDR_CONTROL, 8'h0e);
      i0 = irqs;
      acc(1'b1, ADDR_CONTROL, 8'h4e);
      repeat (3) @(posedge clk);
      check("software flag interrupt", 16'(irqs - i0), 16'h0001);
      acc(1'b1, ADDR_CONTROL, 8'h00);
      u_pins.hold_trig(1'b0);
      wr16(ADDR_CAP_LOW, 16'h0010);
      wr16(ADDR_COUNT_LOW, 16'h0012);
      acc(1'b1, ADDR_MODE, 8'h01);
      i0 = irqs;
      acc(1'b1, ADDR_CONTROL, 8'h04);
      repeat (20) @(posedge clk);
      rd(ADDR_CONTROL, 8'hc4, "down match flags");
      rd(ADDR_COUNT_HIGH, 8'hff, "down reload high byte");
      check("down match interrupt", 16'(irqs - i0), 16'h0001);
      acc(1'b1, ADDR_CONTROL, 8'h00);
      u_pins.hold_trig(1'b1);
      acc(1'b1, ADDR_MODE, 8'h00);
      wr16(ADDR_CAP_LOW, 16'hfffc);
      wr16(ADDR_COUNT_LOW, 16'hfffc);
      i0 = irqs;
      for (int k = 0; k < 3; k++)
      begin
         acc(1'b1, ADDR_CONTROL, bctl[k]);
         repeat (40) @(posedge clk);
         check("rx tick gap", 16'(rx_gap), bgap[k]);
         check("tx tick gap", 16'(tx_gap), 16'h0008);
         rd(ADDR_CONTROL, bctl[k], "no flag in baud mode");
      end
      check("baud interrupts", 16'(irqs - i0), 16'h0000);
      smode <= 2'b00;
      repeat (40) @(posedge clk);
      stop_test();
   end
endmodule
`default_nettype wire
